/* File: src/tdg_pkg.sv */
// package: constants and types shared by the tamper detect gate
// assumes the internal oscillator drives sys_clk at a nominal 50 MHz rate
package tdg_pkg;
  localparam int unsigned OSC_NOMINAL_MHZ = 50;
  localparam int unsigned OSC_TOL_PCT     = 15;
  localparam int unsigned SERIAL_W        = 96;
  localparam int unsigned USER_ID_W       = 256;
  localparam int unsigned HASH_W          = 64;
  localparam int unsigned VOLT_W          = 12;
  localparam int unsigned CNT_W           = 16;
  // gate time in oscillator cycles, 10 us at nominal rate
  localparam int unsigned GATE_US         = 10;
  localparam int unsigned GATE_CYC        = GATE_US * OSC_NOMINAL_MHZ;
  localparam logic [1:0]  ID_SEL_SERIAL   = 2'h0;
  localparam logic [1:0]  ID_SEL_USER     = 2'h1;
  localparam logic [1:0]  ID_SEL_BOTH     = 2'h2;
  typedef enum logic [3:0] {
    TDG_ST_IDLE  = 4'b0001,
    TDG_ST_HASH  = 4'b0010,
    TDG_ST_PASS  = 4'b0100,
    TDG_ST_FAIL  = 4'b1000
  } tdg_state_t;
endpackage

/* File: src/tdg_hash_if.sv */
// interface: hash engine request and result between gate and engine
// assumes both ends run on the oscillator clock
`timescale 1ns/1ns
interface tdg_hash_if;
  import tdg_pkg::*;
  logic                start;
  logic [SERIAL_W+USER_ID_W-1:0] msg;
  logic [1:0]          sel;
  logic                done;
  logic [HASH_W-1:0]   digest;
  modport gate   (output start, output msg, output sel, input done, input digest);
  modport engine (input start, input msg, input sel, output done, output digest);
endinterface

/* File: src/tdg_hash.sv */
// keyed one-way mixing engine, one round per clock over the identifier words
// assumes the key is the same constant that produced the stored reference
`timescale 1ns/1ns
module tdg_hash #(
  parameter logic [63:0] KEY = 64'h5a3c_96e1_0f7b_2d48 // arbitrary
) (
  input  wire logic sys_clk,
  input  wire logic nrst,
  tdg_hash_if.engine hif
);
  import tdg_pkg::*;
  localparam int unsigned ROUNDS = (SERIAL_W + USER_ID_W) / 32;
  logic [HASH_W-1:0] acc_ff, nxt_acc;
  logic [4:0]        idx_ff, nxt_idx;
  logic              busy_ff, nxt_busy;
  logic              done_ff, nxt_done;
  logic [31:0]       word;

  function automatic logic [HASH_W-1:0] mix(input logic [HASH_W-1:0] a, input logic [31:0] w);
    logic [HASH_W-1:0] t;
    t = a ^ {w, ~w} ^ KEY;
    t = {t[50:0], t[63:51]} + {t[22:0], t[63:23]};
    return t ^ (t >> 29);
  endfunction

  always_comb begin
    word = hif.msg[idx_ff*32 +: 32];
    // words not selected still take a round but enter as zero, so the hash covers only chosen ids
    if ((hif.sel == ID_SEL_SERIAL) && (idx_ff >= 5'(SERIAL_W / 32))) begin
      word = 32'h0;
    end
    if ((hif.sel == ID_SEL_USER) && (idx_ff < 5'(SERIAL_W / 32))) begin
      word = 32'h0;
    end
    nxt_acc  = acc_ff;
    nxt_idx  = idx_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    if (hif.start && !busy_ff) begin
      nxt_acc  = KEY;
      nxt_idx  = 5'h0;
      nxt_busy = 1'b1;
    end else if (busy_ff) begin
      nxt_acc = mix(acc_ff, word);
      if (idx_ff == 5'(ROUNDS - 1)) begin
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
      end else begin
        nxt_idx = idx_ff + 5'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      acc_ff  <= '0;
      idx_ff  <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      acc_ff  <= nxt_acc;
      idx_ff  <= nxt_idx;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end

  assign hif.done   = done_ff;
  assign hif.digest = acc_ff;
endmodule

/* File: src/tdg_top.sv */
// top: clock window monitor, voltage alarms, id hash gate, sticky penalties
// assumes sys_clk is the always-running internal oscillator; all else is async
// Functional notes
// - all monitoring runs on the internal oscillator, nominal 50 MHz within 15 percent
// - user clock edge count per gate must lie between programmed low and high bounds
// - count outside the window raises the clock penalty output
// - no logic depends on any external clock for its sequencing
// - failed identifier check holds the design inactive or limited
// - the 96-bit factory serial number feeds the identifier hash
// - the 256-bit user id area may be used alone or with the serial
// - keyed hash compared to stored reference; enable only on match
// - external voltages compared with upper and lower limits; alarm exposed
`timescale 1ns/1ns
module tdg_top
  import tdg_pkg::*;
#(
  parameter int unsigned GATE_CYCLES = GATE_CYC,
  parameter int unsigned NUM_VOLT    = 2
) (
  input  wire logic                          sys_clk,
  input  wire logic                          nrst,
  input  wire logic                          user_clk_in,
  input  wire logic [tdg_pkg::CNT_W-1:0]     freq_lo,
  input  wire logic [tdg_pkg::CNT_W-1:0]     freq_hi,
  input  wire logic [tdg_pkg::SERIAL_W-1:0]  serial_number_word0,
  input  wire logic [tdg_pkg::USER_ID_W-1:0] unique_identifier,
  input  wire logic [1:0]                    id_sel,
  input  wire logic [tdg_pkg::HASH_W-1:0]    ref_hash,
  input  wire logic                          id_check_start,
  input  wire logic [NUM_VOLT*tdg_pkg::VOLT_W-1:0] volt_in,
  input  wire logic [tdg_pkg::VOLT_W-1:0]    volt_lo,
  input  wire logic [tdg_pkg::VOLT_W-1:0]    volt_hi,
  output logic                               clk_penalty,
  output logic                               volt_alarm,
  output logic [NUM_VOLT-1:0]                volt_alarm_vec,
  output logic                               design_enable,
  output logic                               limited_mode,
  output logic                               id_fail
);
  import tdg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // user clock synchroniser and edge counter
  logic              ucs1_ff, ucs2_ff, ucs3_ff;
  logic [CNT_W-1:0]  edge_cnt_ff, nxt_edge_cnt;
  logic [CNT_W-1:0]  gate_cnt_ff, nxt_gate_cnt;
  logic              clk_pen_ff, nxt_clk_pen;
  logic              gate_end;
  logic              rise;

  function automatic logic in_window(input logic [CNT_W-1:0] v, input logic [CNT_W-1:0] lo,
                                     input logic [CNT_W-1:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ucs1_ff <= 1'b0;
      ucs2_ff <= 1'b0;
      ucs3_ff <= 1'b0;
    end else begin
      ucs1_ff <= user_clk_in;
      ucs2_ff <= ucs1_ff;
      ucs3_ff <= ucs2_ff;
    end
  end

  always_comb begin
    rise         = ucs2_ff && !ucs3_ff;
    gate_end     = (gate_cnt_ff == CNT_W'(GATE_CYCLES - 1));
    nxt_gate_cnt = gate_end ? '0 : gate_cnt_ff + CNT_W'(1);
    nxt_edge_cnt = edge_cnt_ff;
    if (rise && (edge_cnt_ff != '1)) begin
      nxt_edge_cnt = edge_cnt_ff + CNT_W'(1);
    end
    if (gate_end) begin
      nxt_edge_cnt = '0;
    end
    nxt_clk_pen = clk_pen_ff;
    // bounds must already include the oscillator tolerance; a stopped clock reads 0
    if (gate_end && !in_window(edge_cnt_ff, freq_lo, freq_hi)) begin
      nxt_clk_pen = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      edge_cnt_ff <= '0;
      gate_cnt_ff <= '0;
      clk_pen_ff  <= 1'b0;
    end else begin
      edge_cnt_ff <= nxt_edge_cnt;
      gate_cnt_ff <= nxt_gate_cnt;
      clk_pen_ff  <= nxt_clk_pen;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // voltage alarm comparators; inputs come from another domain, so two flops
  logic [NUM_VOLT*VOLT_W-1:0] vs1_ff, vs2_ff, vs3_ff;
  logic [2:0]                 vfill_ff, nxt_vfill;
  logic [NUM_VOLT-1:0]        valm_ff, nxt_valm;
  logic                       vany_ff, nxt_vany;
  logic                       vcmp;

  always_comb begin
    // reset zeros in the pipe would read as under-voltage, so wait until it is full;
    // a word caught mid-change is skipped by asking two samples to agree
    nxt_vfill = {vfill_ff[1:0], 1'b1};
    vcmp      = vfill_ff[2] && (vs2_ff == vs3_ff);
    nxt_valm  = valm_ff;
    for (int i = 0; i < NUM_VOLT; i++) begin
      if (vcmp && ((vs2_ff[i*VOLT_W +: VOLT_W] > volt_hi) || (vs2_ff[i*VOLT_W +: VOLT_W] < volt_lo))) begin
        nxt_valm[i] = 1'b1;
      end
    end
    nxt_vany = |nxt_valm;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      vs1_ff   <= '0;
      vs2_ff   <= '0;
      vs3_ff   <= '0;
      vfill_ff <= '0;
      valm_ff  <= '0;
      vany_ff  <= 1'b0;
    end else begin
      vs1_ff   <= volt_in;
      vs2_ff   <= vs1_ff;
      vs3_ff   <= vs2_ff;
      vfill_ff <= nxt_vfill;
      valm_ff <= nxt_valm;
      vany_ff <= nxt_vany;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // identifier hash check
  tdg_hash_if hif ();
  tdg_state_t        st_ff, nxt_st;
  logic              hstart_ff, nxt_hstart;
  logic              st1_ff, st2_ff, st3_ff;
  logic              en_ff, nxt_en;
  logic              lim_ff, nxt_lim;
  logic              fail_ff, nxt_fail;

  tdg_hash u_hash (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .hif     (hif)
  );

  assign hif.start = hstart_ff;
  assign hif.msg   = {unique_identifier, serial_number_word0};
  assign hif.sel   = id_sel;

  always_comb begin
    nxt_st     = st_ff;
    nxt_hstart = 1'b0;
    nxt_fail   = fail_ff;
    case (st_ff)
      TDG_ST_IDLE: begin
        if (st2_ff && !st3_ff) begin
          nxt_st     = TDG_ST_HASH;
          nxt_hstart = 1'b1;
        end
      end
      TDG_ST_HASH: begin
        if (hif.done) begin
          if (hif.digest == ref_hash) begin
            nxt_st = TDG_ST_PASS;
          end else begin
            nxt_st   = TDG_ST_FAIL;
            nxt_fail = 1'b1;
          end
        end
      end
      TDG_ST_PASS: nxt_st = TDG_ST_PASS;
      TDG_ST_FAIL: nxt_st = TDG_ST_FAIL;
      default:     nxt_st = TDG_ST_IDLE;
    endcase
    // any penalty drops full operation to limited mode
    nxt_en  = (nxt_st == TDG_ST_PASS) && !nxt_clk_pen && !nxt_vany;
    nxt_lim = !nxt_en;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff     <= TDG_ST_IDLE;
      hstart_ff <= 1'b0;
      st1_ff    <= 1'b0;
      st2_ff    <= 1'b0;
      st3_ff    <= 1'b0;
      en_ff     <= 1'b0;
      lim_ff    <= 1'b1;
      fail_ff   <= 1'b0;
    end else begin
      st_ff     <= nxt_st;
      hstart_ff <= nxt_hstart;
      st1_ff    <= id_check_start;
      st2_ff    <= st1_ff;
      st3_ff    <= st2_ff;
      en_ff     <= nxt_en;
      lim_ff    <= nxt_lim;
      fail_ff   <= nxt_fail;
    end
  end

  assign clk_penalty    = clk_pen_ff;
  assign volt_alarm     = vany_ff;
  assign volt_alarm_vec = valm_ff;
  assign design_enable  = en_ff;
  assign limited_mode   = lim_ff;
  assign id_fail        = fail_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_gate_bad;
    gate_end && !in_window(edge_cnt_ff, freq_lo, freq_hi);
  endsequence

  a_clk_pen_set: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_gate_bad |=> clk_penalty) else $error("clock penalty not raised");
  a_clk_pen_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_penalty |=> clk_penalty) else $error("clock penalty dropped");
  a_volt_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    volt_alarm |=> volt_alarm) else $error("voltage alarm dropped");
  a_volt_high: assert property (@(posedge sys_clk) disable iff (!nrst)
    vcmp && (vs2_ff[VOLT_W-1:0] > volt_hi) |=> volt_alarm_vec[0]) else $error("high voltage missed");
  a_volt_low: assert property (@(posedge sys_clk) disable iff (!nrst)
    vcmp && (vs2_ff[VOLT_W-1:0] < volt_lo) |=> volt_alarm) else $error("low voltage missed");
  a_id_match: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_ff == TDG_ST_HASH && hif.done && hif.digest != ref_hash) |=> id_fail ##1 !design_enable)
    else $error("mismatch did not fail");
  a_enable_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
    design_enable |-> (st_ff == TDG_ST_PASS) && !clk_penalty && !volt_alarm && !limited_mode)
    else $error("enable without pass");
  a_gate_period: assert property (@(posedge sys_clk) disable iff (!nrst)
    gate_end |=> (gate_cnt_ff == '0) && (edge_cnt_ff == '0)) else $error("gate did not restart");
endmodule

/* File: tb/tdg_partner.sv */
// partner: monitored user clock source and processor-side reference hash
// assumes the bench starts the clock freely and keeps KEY equal to the engine key
`timescale 1ns/1ns
module tdg_partner
  import tdg_pkg::*;
#(
  parameter logic [63:0] KEY     = 64'h5a3c_96e1_0f7b_2d48, // arbitrary, same as engine default
  parameter int unsigned HALF_NS = 21
) (
  input  wire logic run,
  output logic      user_clk
);
  ////////////////////////////////////////////////////////////////////////////////
  // odd half period keeps user edges drifting against sys_clk
  initial begin
    user_clk = 1'b0;
    forever begin
      #(HALF_NS);
      user_clk <= run ? ~user_clk : 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // skipped words enter as zero, selection 3 acts as both
  function automatic logic [HASH_W-1:0] ref_digest(input logic [SERIAL_W-1:0] sn,
                                                   input logic [USER_ID_W-1:0] uid,
                                                   input logic [1:0] sel);
    logic [SERIAL_W+USER_ID_W-1:0] m;
    logic [63:0]                   acc;
    logic [63:0]                   t;
    logic [31:0]                   w;
    m = {uid, sn};
    if (sel == ID_SEL_SERIAL) m[SERIAL_W+USER_ID_W-1:SERIAL_W] = '0;
    if (sel == ID_SEL_USER) m[SERIAL_W-1:0] = '0;
    acc = KEY;
    for (int i = 0; i < 11; i++) begin
      w = m[i*32 +: 32];
      t = acc ^ {w, ~w} ^ KEY;
      t = {t[50:0], t[63:51]} + {t[22:0], t[63:23]};
      acc = t ^ (t >> 29);
    end
    return acc;
  endfunction
endmodule

/* File: tb/tb_tdg_top.sv */
// testbench: self-checking scenarios for the tamper detect gate
// assumes a 20-cycle gate window and a partner clock of about 4.8 edges per window
`timescale 1ns/1ns
module tb_tdg_top;
  import tdg_pkg::*;
  localparam int unsigned GATE = 20;
  logic                  sys_clk;
  logic                  nrst;
  logic                  user_run;
  logic                  user_clk_in;
  logic [CNT_W-1:0]      freq_lo;
  logic [CNT_W-1:0]      freq_hi;
  logic [SERIAL_W-1:0]   sn;
  logic [USER_ID_W-1:0]  uid;
  logic [1:0]            id_sel;
  logic [HASH_W-1:0]     ref_hash;
  logic                  id_check_start;
  logic [2*VOLT_W-1:0]   volt_in;
  logic [VOLT_W-1:0]     volt_lo;
  logic [VOLT_W-1:0]     volt_hi;
  logic                  clk_penalty;
  logic                  volt_alarm;
  logic [1:0]            volt_alarm_vec;
  logic                  design_enable;
  logic                  limited_mode;
  logic                  id_fail;
  int                    num_errors;
  int                    checks_done;
  tdg_partner u_tdg_partner (.run(user_run), .user_clk(user_clk_in));
  tdg_top #(.GATE_CYCLES(GATE), .NUM_VOLT(2)) u_tdg_top (
    .sys_clk(sys_clk), .nrst(nrst), .user_clk_in(user_clk_in), .freq_lo(freq_lo), .freq_hi(freq_hi),
    .serial_number_word0(sn), .unique_identifier(uid), .id_sel(id_sel), .ref_hash(ref_hash),
    .id_check_start(id_check_start), .volt_in(volt_in), .volt_lo(volt_lo), .volt_hi(volt_hi),
    .clk_penalty(clk_penalty), .volt_alarm(volt_alarm), .volt_alarm_vec(volt_alarm_vec),
    .design_enable(design_enable), .limited_mode(limited_mode), .id_fail(id_fail));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic do_reset();
    @(posedge sys_clk);
    nrst           <= 1'b0;
    id_check_start <= 1'b0;
    cycles(16);
    nrst <= 1'b1;
    cycles(1);
  endtask
  // bounded wait for the identifier verdict
  task automatic run_id(input logic [1:0] sel, input logic [63:0] rh);
    int n;
    id_sel         <= sel;
    ref_hash       <= rh;
    id_check_start <= 1'b1;
    n = 0;
    while (design_enable !== 1'b1 && id_fail !== 1'b1) begin
      @(negedge sys_clk);
      n++;
      if (n > 60) begin
        check("id_timeout", 1'b1, 1'b0);
        finish_test();
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    do_reset();
    @(negedge sys_clk);
    check("rst_outputs", {clk_penalty, volt_alarm, volt_alarm_vec, design_enable, id_fail}, '0);
    check("rst_limited", limited_mode, 1'b1);
  endtask
  // every selection code passes with its own reference
  task automatic t_id_sel();
    for (int s = 0; s < 4; s++) begin
      do_reset();
      run_id(s[1:0], u_tdg_partner.ref_digest(sn, uid, s[1:0]));
      check("id_pass_en", {design_enable, limited_mode, id_fail}, 3'b100);
    end
  endtask
  // a wrong reference fails and a later start cannot retry
  task automatic t_id_fail();
    do_reset();
    run_id(ID_SEL_BOTH, u_tdg_partner.ref_digest(sn, uid, ID_SEL_USER));
    check("id_fail", {design_enable, limited_mode, id_fail}, 3'b011);
    @(posedge sys_clk);
    id_check_start <= 1'b0;
    ref_hash       <= u_tdg_partner.ref_digest(sn, uid, ID_SEL_BOTH);
    cycles(8);
    id_check_start <= 1'b1;
    cycles(40);
    check("id_no_retry", {design_enable, id_fail}, 2'b01);
  endtask
  task automatic t_clock();
    do_reset();
    run_id(ID_SEL_BOTH, u_tdg_partner.ref_digest(sn, uid, ID_SEL_BOTH));
    cycles(3 * GATE);
    check("clk_in_range", {clk_penalty, design_enable}, 2'b01);
    user_run <= 1'b0;
    cycles(2 * GATE + 5);
    check("clk_stopped", {clk_penalty, design_enable, limited_mode}, 3'b101);
    user_run <= 1'b1;
    cycles(3 * GATE);
    check("clk_sticky", clk_penalty, 1'b1);
    do_reset();
    freq_hi <= 16'h0003;
    cycles(2 * GATE + 5);
    check("clk_too_fast", clk_penalty, 1'b1);
    freq_hi <= 16'h0006;
  endtask
  // limits are inclusive; alarms are sticky per channel
  task automatic t_volt();
    do_reset();
    volt_in <= {12'he00, 12'h100};
    cycles(6);
    check("volt_edges", {volt_alarm, volt_alarm_vec}, 3'h0);
    volt_in <= {12'he01, 12'h100};
    cycles(5);
    check("volt_high", {volt_alarm, volt_alarm_vec}, 3'h6);
    volt_in <= {12'h800, 12'h0ff};
    cycles(5);
    check("volt_low", {volt_alarm, volt_alarm_vec}, 3'h7);
    volt_in <= {12'h800, 12'h800};
    cycles(6);
    check("volt_sticky", {volt_alarm, volt_alarm_vec}, 3'h7);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    num_errors     = 0;
    checks_done    = 0;
    nrst           = 1'b0;
    user_run       = 1'b1;
    freq_lo        = 16'h0003;
    freq_hi        = 16'h0006;
    sn             = 96'h0123_4567_89ab_cdef_0011_2233;
    uid            = {4{64'hfedc_ba98_7654_3210}};
    id_sel         = 2'h2;
    ref_hash       = 64'h0;
    id_check_start = 1'b0;
    volt_in        = {12'h800, 12'h800};
    volt_lo        = 12'h100;
    volt_hi        = 12'he00;
    t_reset();
    t_id_sel();
    t_id_fail();
    t_clock();
    t_volt();
    finish_test();
  end
endmodule
